// ### src/dtbct_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dtbct_timer
  import dtbct_pkg::*;
(
  input wire logic core_clk, // 40 MHz clock standing in for the oscillator
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic [31:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic wb_we_i, // wishbone write enable
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic full_halt, // high while device is in full halt mode
  input wire logic capture_input_pin, // capture pin
  output logic first_timebase_irq, // first timebase interrupt request
  output logic second_timebase_irq, // second timebase interrupt request
  output logic capture_irq, // capture interrupt request
  output logic halt_wakeup // capture wake request out of halt
);
  import dtbct_pkg::*;

  logic [4:0] pre_q;
  logic tick;
  logic [7:0] cnt1_q;
  logic [7:0] cnt2_q;
  logic [7:0] reload_q;
  logic [7:0] capt_q;
  logic ovf1_q;
  logic tb1_flag_q;
  logic tb2_flag_q;
  logic cap_flag_q;
  logic tb1_ie_q;
  logic tb2_ie_q;
  logic cap_ie_q;
  logic pds_q;
  logic sync1_q;
  logic sync2_q;
  logic pin_last_q;
  logic edge_seen;
  logic ovf1_evt;
  logic ovf2_evt;
  logic cap_evt;
  logic bus_req;
  logic rd_acc;
  logic wr_acc;
  logic [7:0] rd_byte;
  logic lane0_wr;
  logic prime1_q;
  logic prime2_q;
  logic primed_q;
  logic csr1_rd;
  logic csr2_rd;
  logic capt_rd;
  logic csr1_wr;
  logic csr2_wr;
  logic reload_wr;
  logic wrap1;
  logic wrap2;

  // strip the word alignment: register index is the byte address over four
  function automatic logic hit(input logic [31:0] adr, input logic [ADDR_W-1:0] idx);
    hit = (adr[31:2] == {22'h000000, idx}) && (adr[1:0] == 2'b00);
  endfunction

  // status byte layouts; reserved positions read as zero
  function automatic logic [7:0] pack_csr2(input logic flag, input logic ie);
    pack_csr2 = ZERO8;
    pack_csr2[CSR2_FLAG_BIT] = flag;
    pack_csr2[CSR2_IE_BIT] = ie;
  endfunction

  function automatic logic [7:0] pack_csr1(input logic tb1_flag, input logic tb1_ie, input logic pds,
                                           input logic cap_flag, input logic cap_ie);
    pack_csr1 = ZERO8;
    pack_csr1[CSR1_FLAG_BIT] = tb1_flag;
    pack_csr1[CSR1_IE_BIT] = tb1_ie;
    pack_csr1[CSR1_PDS_BIT] = pds;
    pack_csr1[CSR1_CFLAG_BIT] = cap_flag;
    pack_csr1[CSR1_CIE_BIT] = cap_ie;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_acc = bus_req && !wb_we_i;
  assign wr_acc = bus_req && wb_we_i;
  assign lane0_wr = wr_acc && wb_sel_i[0];

  // register decodes, shared by the flag clears and the control writes
  assign csr1_rd = rd_acc && hit(wb_adr_i, ADDR_IDX_CSR1);
  assign csr2_rd = rd_acc && hit(wb_adr_i, ADDR_IDX_CSR2);
  assign capt_rd = rd_acc && hit(wb_adr_i, ADDR_IDX_CAPT);
  assign csr1_wr = lane0_wr && hit(wb_adr_i, ADDR_IDX_CSR1);
  assign csr2_wr = lane0_wr && hit(wb_adr_i, ADDR_IDX_CSR2);
  assign reload_wr = lane0_wr && hit(wb_adr_i, ADDR_IDX_RELOAD);

  // shared divide-by-32 enable; frozen in full halt so both counters stop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 5'h00;
    end else if (!full_halt) begin
      pre_q <= (pre_q == PRESCALE_LAST) ? 5'h00 : pre_q + 5'h01;
    end
  end
  assign tick = !full_halt && (pre_q == PRESCALE_LAST);
  assign wrap1 = tick && (cnt1_q == CNT1_LAST);
  assign wrap2 = tick && (cnt2_q == CNT2_LAST);

  // first counter: hidden from software, 250 steps from 00h to f9h
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt1_q <= ZERO8;
    end else if (wrap1) begin
      cnt1_q <= ZERO8;
    end else if (tick) begin
      cnt1_q <= cnt1_q + 8'h01;
    end
  end

  // half-period phase: with period select it takes two wraps per event
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf1_q <= 1'b0;
    end else if (wrap1) begin
      ovf1_q <= pds_q ? !ovf1_q : 1'b0;
    end
  end
  assign ovf1_evt = wrap1 && (!pds_q || ovf1_q);

  // second counter: starts at reset reload value, reloads on overflow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt2_q <= RELOAD_RST;
    end else if (wrap2) begin
      cnt2_q <= reload_q;
    end else if (tick) begin
      cnt2_q <= cnt2_q + 8'h01;
    end
  end
  assign ovf2_evt = wrap2;

  // reload register is only sampled at overflow, so writes need no shadow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_q <= RELOAD_RST;
    end else if (reload_wr) begin
      reload_q <= wb_dat_i[7:0];
    end
  end

  // two-stage synchroniser; nothing but the second stage reads the first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= capture_input_pin;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_last_q <= 1'b0;
    end else begin
      pin_last_q <= sync2_q;
    end
  end

  // the chain resets to zero while the pin may idle high; edges are ignored
  // until all three stages hold the real pin level, so a genuine edge in the
  // first cycle after reset, before the first sampling edge, is lost
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prime1_q <= 1'b0;
      prime2_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      prime1_q <= 1'b1;
      prime2_q <= prime1_q;
      primed_q <= prime2_q;
    end
  end
  // edge logic runs even in halt so a capture can wake the device
  assign edge_seen = primed_q && (sync2_q ^ pin_last_q);
  assign cap_evt = edge_seen && !cap_flag_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      capt_q <= ZERO8;
    end else if (cap_evt) begin
      capt_q <= cnt1_q;
    end
  end

  // timebase flags: hardware set wins over a clearing read in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb1_flag_q <= 1'b0;
    end else if (ovf1_evt) begin
      tb1_flag_q <= 1'b1;
    end else if (csr1_rd) begin
      tb1_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb2_flag_q <= 1'b0;
    end else if (ovf2_evt) begin
      tb2_flag_q <= 1'b1;
    end else if (csr2_rd) begin
      tb2_flag_q <= 1'b0;
    end
  end

  // reset value is defined here although software still reads once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_flag_q <= 1'b0;
    end else if (cap_evt) begin
      cap_flag_q <= 1'b1;
    end else if (capt_rd) begin
      cap_flag_q <= 1'b0;
    end
  end

  // control bits; the flag positions are not writable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb1_ie_q <= 1'b0;
    end else if (csr1_wr) begin
      tb1_ie_q <= wb_dat_i[CSR1_IE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_ie_q <= 1'b0;
    end else if (csr1_wr) begin
      cap_ie_q <= wb_dat_i[CSR1_CIE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pds_q <= 1'b0;
    end else if (csr1_wr) begin
      pds_q <= wb_dat_i[CSR1_PDS_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb2_ie_q <= 1'b0;
    end else if (csr2_wr) begin
      tb2_ie_q <= wb_dat_i[CSR2_IE_BIT];
    end
  end

  // read mux; first counter deliberately absent, unmapped reads give zero
  always_comb begin
    rd_byte = ZERO8;
    if (hit(wb_adr_i, ADDR_IDX_CSR2)) begin
      rd_byte = pack_csr2(tb2_flag_q, tb2_ie_q);
    end else if (hit(wb_adr_i, ADDR_IDX_RELOAD)) begin
      rd_byte = reload_q;
    end else if (hit(wb_adr_i, ADDR_IDX_CNT2)) begin
      rd_byte = cnt2_q;
    end else if (hit(wb_adr_i, ADDR_IDX_CSR1)) begin
      rd_byte = pack_csr1(tb1_flag_q, tb1_ie_q, pds_q, cap_flag_q, cap_ie_q);
    end else if (hit(wb_adr_i, ADDR_IDX_CAPT)) begin
      rd_byte = capt_q;
    end
  end

  // one wait-free ack per request; ack drops the cycle after
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read data is zero for writes so a stale byte never shows on the bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= rd_acc ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // interrupt requests follow flag and enable one cycle later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_timebase_irq <= 1'b0;
    end else begin
      first_timebase_irq <= tb1_flag_q && tb1_ie_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_timebase_irq <= 1'b0;
    end else begin
      second_timebase_irq <= tb2_flag_q && tb2_ie_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= cap_flag_q && cap_ie_q;
    end
  end

  // only the capture may wake from halt; the timebases are frozen there anyway
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_wakeup <= 1'b0;
    end else begin
      halt_wakeup <= cap_flag_q && cap_ie_q && full_halt;
    end
  end
endmodule // dtbct_timer
`default_nettype wire

// ### src/dtbct_pkg.sv
`default_nettype none
package dtbct_pkg;
  // register indices; the bus byte address is the index times four
  localparam logic [7:0] ADDR_IDX_CSR2 = 8'h08;
  localparam logic [7:0] ADDR_IDX_RELOAD = 8'h09;
  localparam logic [7:0] ADDR_IDX_CNT2 = 8'h0a;
  localparam logic [7:0] ADDR_IDX_CSR1 = 8'h0b;
  localparam logic [7:0] ADDR_IDX_CAPT = 8'h0c;
  localparam int ADDR_W = 8;
  // second control/status field positions
  localparam int CSR2_FLAG_BIT = 0;
  localparam int CSR2_IE_BIT = 1;
  // first control/status field positions
  localparam int CSR1_FLAG_BIT = 3;
  localparam int CSR1_IE_BIT = 4;
  localparam int CSR1_PDS_BIT = 5;
  localparam int CSR1_CFLAG_BIT = 6;
  localparam int CSR1_CIE_BIT = 7;
  // prescaler: oscillator / 32
  localparam int PRESCALE_DIV = 32;
  localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);
  // first counter wraps after f9h
  localparam logic [7:0] CNT1_LAST = 8'hf9;
  localparam logic [7:0] CNT2_LAST = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  // second timebase programmable range and first timebase base period at 8 MHz oscillator, in ns
  localparam int TB2_STEP_NS = 4000;
  localparam int TB2_MAX_NS = 1024000;
  localparam int TB1_BASE_NS = 1000000;
  localparam int OSC_MHZ = 8;
  typedef enum logic {
    DTBCT_PER_SINGLE,
    DTBCT_PER_DOUBLE
  } dtbct_period_t;
endpackage
`default_nettype wire

// ### tb/dtbct_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dtbct_chk (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic [31:0] wb_adr_i, // address
  input wire logic wb_we_i, // write
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic full_halt, // halt
  input wire logic first_timebase_irq, // tb1 irq
  input wire logic second_timebase_irq, // tb2 irq
  input wire logic capture_irq, // capture irq
  input wire logic halt_wakeup // wake
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // flag clears at the ack edge, so the registered request is low one edge later
  wire rd_ack = wb_ack_o && !wb_we_i;
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_write_reads_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("write data");
  a_upper_bits_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits");
  a_tb1_read_clears: assert property (rd_ack && wb_adr_i == 32'h2c |-> ##[1:2] !first_timebase_irq)
    else $error("tb1 clear");
  a_tb2_read_clears: assert property (rd_ack && wb_adr_i == 32'h20 |=> !second_timebase_irq)
    else $error("tb2 clear");
  a_capt_read_clears: assert property (rd_ack && wb_adr_i == 32'h30 |=> !capture_irq [*2])
    else $error("capture clear");
  a_wake_gated: assert property (halt_wakeup |-> capture_irq && $past(full_halt))
    else $error("wake gate");
  a_wake_in_halt: assert property (capture_irq && full_halt && !wb_ack_o |=> halt_wakeup)
    else $error("no wake");
endmodule // dtbct_chk
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dtbct_pkg::*;
  logic core_clk = 1'h0, rst_b = 1'h0, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic full_halt = 1'h0, capture_input_pin = 1'h1, wb_ack_o, first_timebase_irq;
  logic second_timebase_irq, capture_irq, halt_wakeup;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] v1, v2;
  int n_fail = 0, total_checks = 0, cyc_n = 0, t1, d;
  wire [3:0] irqs = {halt_wakeup, capture_irq, second_timebase_irq, first_timebase_irq};
  dtbct_timer dtbct_timer_inst (.core_clk, .rst_b, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .full_halt, .capture_input_pin, .first_timebase_irq,
    .second_timebase_irq, .capture_irq, .halt_wakeup);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc_n <= cyc_n + 1;
  task print_verdict;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // called at a clock edge; one idle cycle follows every transfer
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [7:0] rv);
    int i;
    wb_adr_i <= {24'h0, a};
    wb_we_i <= w;
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= 4'h1;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++) @(posedge core_clk);
    chk("ack", 16'h1, {15'h0, wb_ack_o});
    if (i == 20) print_verdict;
    rv = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] rv);
    xfer(a, 1'h0, 8'h0, rv);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] nu;
    xfer(a, 1'h1, wd, nu);
  endtask
  task wait_hi(input int b, input int lim);
    int i;
    for (i = 0; i < lim && irqs[b] !== 1'h1; i++) @(posedge core_clk);
    if (i == lim) begin
      chk("irq", 16'h1, 16'h0);
      print_verdict;
    end
  endtask
  // rise-to-rise spacing of a request, clearing its flag after each rise
  task per(input int b, input logic [7:0] a, input int lim, output int dd);
    int t;
    wait_hi(b, lim);
    t = cyc_n;
    rd(a, v1);
    wait_hi(b, lim);
    dd = cyc_n - t;
    rd(a, v1);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    for (int a = 32; a <= 48; a += 4) begin
      rd(8'(a), v1);
      chk("reset value", 16'h0, {8'h0, v1});
    end
    rd(8'h34, v1);
    chk("unmapped", 16'h0, {8'h0, v1});
    wr(8'h24, 8'hf0);
    wr(8'h20, 8'h03);
    rd(8'h20, v1);
    chk("csr2", 16'h2, {8'h0, v1});
    per(1, 8'h20, 9000, d);
    chk("tb2 period", 16'(PRESCALE_DIV * 16), d[15:0]);
    rd(8'h28, v1);
    chk("cnt2 after reload", 16'hf, {12'h0, v1[7:4]});
    wr(8'h24, 8'hc0);
    per(1, 8'h20, 3000, d);
    chk("tb2 new reload", 16'(PRESCALE_DIV * 64), d[15:0]);
    rd(8'h2c, v1);
    chk("tb1 stale flag", 16'h1, {15'h0, v1[CSR1_FLAG_BIT]});
    wr(8'h2c, 8'h10);
    per(0, 8'h2c, 9000, d);
    chk("tb1 period", 16'(PRESCALE_DIV * 250), d[15:0]);
    chk("tb1 flag", 16'h1, {15'h0, v1[CSR1_FLAG_BIT]});
    wr(8'h2c, 8'h30);
    per(0, 8'h2c, 17000, d);
    chk("tb1 doubled", 16'(PRESCALE_DIV * 500), d[15:0]);
    wr(8'h2c, 8'hc0);
    rd(8'h2c, v1);
    chk("capture flag write", 16'h4, {13'h0, v1[7:5]});
    capture_input_pin <= ~capture_input_pin;
    t1 = cyc_n;
    wait_hi(2, 20);
    repeat (50) @(posedge core_clk);
    capture_input_pin <= ~capture_input_pin;
    repeat (10) @(posedge core_clk);
    rd(8'h30, v1);
    while (cyc_n < t1 + 320) @(posedge core_clk);
    capture_input_pin <= ~capture_input_pin;
    wait_hi(2, 20);
    rd(8'h30, v2);
    chk("capture", ({8'h0, v1} + 16'd10) % 16'd250, {8'h0, v2});
    full_halt <= 1'h1;
    @(posedge core_clk);
    rd(8'h28, v1);
    repeat (100) @(posedge core_clk);
    rd(8'h28, v2);
    chk("cnt2 in halt", {8'h0, v1}, {8'h0, v2});
    capture_input_pin <= ~capture_input_pin;
    wait_hi(3, 20);
    rd(8'h30, v1);
    full_halt <= 1'h0;
    print_verdict;
  end
endmodule // tb_top
bind dtbct_timer dtbct_chk dtbct_chk_inst (.core_clk, .rst_b, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .full_halt, .first_timebase_irq, .second_timebase_irq, .capture_irq, .halt_wakeup);
`default_nettype wire
